// file: logic/psw_defines.svh
// Constants for the program space data window
`ifndef PSW_DEFINES_SVH
`define PSW_DEFINES_SVH
`define PSW_DADDR_W      16
`define PSW_PADDR_W      23
`define PSW_PWORD_W      24
`define PSW_DATA_W       16
`define PSW_PAGE_W       8
`define PSW_OFS_W        15
`define PSW_WIN_MSB      15
`define PSW_CTRL_WIN_BIT 2
`define PSW_PAGE_RST     8'h00
`define PSW_CTRL_RST     16'h0000
`define PSW_XTRA_MOVE    2'h1
`define PSW_XTRA_OTHER   2'h2
`define PSW_XTRA_NONE    2'h0
`define PSW_STALL_MAX    3'h3
`define PSW_RUN_SAT      3'h7
`endif

// file: logic/psw_pkg.sv
// Types for the program space data window
package psw_pkg;
  typedef enum logic [1:0] {
    PSW_IDLE  = 2'b00,
    PSW_FETCH = 2'b01,
    PSW_DONE  = 2'b10
  } psw_state_t;
endpackage

// file: logic/psw_fetch_if.sv
// Program memory fetch carrier between window and stall counter
`timescale 1ns/1ps
interface psw_fetch_if;
  logic       start;
  logic [1:0] extra;
  logic       busy;
  logic       last;
  modport ctl (output start, output extra, input busy, input last);
  modport cnt (input start, input extra, output busy, output last);
endinterface

// file: logic/psw_stall_cnt.sv
// Extra cycle counter for window reads
`timescale 1ns/1ps
`include "psw_defines.svh"
module psw_stall_cnt
  import psw_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Fetch carrier
  psw_fetch_if.cnt  fif
);
  logic [1:0] left_q;

  // Counts down the added instruction cycles
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      left_q <= `PSW_XTRA_NONE;
    end else if (fif.start) begin
      left_q <= fif.extra;
    end else if (left_q != `PSW_XTRA_NONE) begin
      left_q <= left_q - 2'h1;
    end
  end

  assign fif.busy = (left_q != `PSW_XTRA_NONE);
  assign fif.last = (left_q == `PSW_XTRA_MOVE);
endmodule // psw_stall_cnt

// file: logic/psw_window.sv
// Program space data window: maps upper data space onto a program page
// What this block does
// - Data addresses 8000h and up form a window onto one program page.
// - Window read only when address MSB is one and enable bit set.
// - Eight-bit page register picks one of 256 pages of 16K words.
// - Program address is page register over lower 15 address bits.
// - Lower 15 data address bits map straight onto program address bits.
// - A window read returns the lower 16 bits of the 24-bit word.
// - Except in other repeat iterations, a window read adds extra cycles for the two fetches.
// - Window access is suspended while a table instruction runs.
// - Outside repeat loops, word and double moves take one extra cycle.
// - Outside repeat loops, other instructions take two extra cycles.
// - In repeat loops, first, last, pre- and post-interrupt iterations add two.
// - Other repeat iterations complete the window access in one cycle.
`timescale 1ns/1ps
`include "psw_defines.svh"
module psw_window
  import psw_pkg::*;
#(
  parameter int PAGE_W = `PSW_PAGE_W,
  parameter int OFS_W  = `PSW_OFS_W
)(
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rst,
  // Core control and page register writes
  input  wire logic                       ctrl_we,
  input  wire logic [`PSW_DATA_W-1:0]     ctrl_wdata,
  input  wire logic                       page_we,
  input  wire logic [PAGE_W-1:0]          page_wdata,
  output logic [`PSW_DATA_W-1:0]          core_control_register,
  output logic [PAGE_W-1:0]               window_page_register,
  // Data read request from the core
  input  wire logic                       rd_req,
  input  wire logic [`PSW_DADDR_W-1:0]    data_effective_address,
  input  wire logic                       is_move,
  input  wire logic                       in_repeat,
  input  wire logic                       rpt_edge,
  input  wire logic                       table_busy,
  output logic                            rd_stall,
  output logic                            rd_valid,
  output logic [`PSW_DATA_W-1:0]          rd_data,
  // Data memory port
  output logic                            dmem_re,
  output logic [`PSW_DADDR_W-1:0]         dmem_addr,
  input  wire logic [`PSW_DATA_W-1:0]     dmem_rdata,
  // Program memory port
  output logic                            pmem_re,
  output logic [PAGE_W+OFS_W-1:0]         pmem_addr,
  input  wire logic [`PSW_PWORD_W-1:0]    pmem_rdata
);
  // Widths are tied to the page over offset split of the program address
  if (PAGE_W != `PSW_PAGE_W || OFS_W != `PSW_OFS_W) begin : g_bad_split
    $error("psw_window: page and offset widths are fixed by the address split");
  end

  psw_fetch_if fif ();
  psw_state_t  state_q;
  logic        win_hit;
  logic        win_en;
  logic        take_win;
  logic [1:0]  extra;

  // Counter for the added cycles
  psw_stall_cnt u_cnt (
    .sys_clk (sys_clk),
    .rst     (rst),
    .fif     (fif)
  );

  // Control register; enable comes out of reset clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      core_control_register <= `PSW_CTRL_RST;
    end else if (ctrl_we) begin
      core_control_register <= ctrl_wdata;
    end
  end

  // Page register, eight bits, 256 pages
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      window_page_register <= `PSW_PAGE_RST;
    end else if (page_we) begin
      window_page_register <= page_wdata;
    end
  end

  // Window decode; table accesses hold it off to avoid fetch port clashes
  assign win_en   = core_control_register[`PSW_CTRL_WIN_BIT];
  assign win_hit  = data_effective_address[`PSW_WIN_MSB] & win_en;
  assign take_win = rd_req & win_hit & ~table_busy & (state_q == PSW_IDLE);

  // Added cycle count picks repeat-loop case first
  always_comb begin
    if (in_repeat && !rpt_edge) begin
      extra = `PSW_XTRA_NONE;
    end else if (in_repeat) begin
      extra = `PSW_XTRA_OTHER;
    end else if (is_move) begin
      extra = `PSW_XTRA_MOVE;
    end else begin
      extra = `PSW_XTRA_OTHER;
    end
  end

  assign fif.start = take_win & (extra != `PSW_XTRA_NONE);
  assign fif.extra = extra;

  // Window read sequencer
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= PSW_IDLE;
    end else begin
      case (state_q)
        PSW_IDLE: begin
          if (fif.start) state_q <= PSW_FETCH;
        end
        PSW_FETCH: begin
          if (fif.last) state_q <= PSW_DONE;
        end
        PSW_DONE: begin
          state_q <= PSW_IDLE;
        end
        default: begin
          state_q <= PSW_IDLE;
        end
      endcase
    end
  end

  // Program address is page over offset; the word pitch of 2 lives in the offset
  assign pmem_addr = {window_page_register, data_effective_address[OFS_W-1:0]};
  assign pmem_re   = take_win | (state_q == PSW_FETCH);
  assign dmem_re   = rd_req & ~win_hit;
  assign dmem_addr = data_effective_address;

  // Stall while the window is waiting, held off by table use or counting
  assign rd_stall = (rd_req & win_hit & table_busy) | fif.start | (state_q == PSW_FETCH);

  // Answer register; only the low word of the program word is returned
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_valid <= 1'b0;
      rd_data  <= '0;
    end else begin
      rd_valid <= 1'b0;
      if (rd_req && !win_hit) begin
        rd_valid <= 1'b1;
        rd_data  <= dmem_rdata;
      end else if ((take_win && extra == `PSW_XTRA_NONE) || (state_q == PSW_FETCH && fif.last)) begin
        rd_valid <= 1'b1;
        rd_data  <= pmem_rdata[`PSW_DATA_W-1:0];
      end
    end
  end

  // Checks
  sequence s_move_win;
    rd_req && win_hit && !table_busy && state_q == PSW_IDLE && !in_repeat && is_move;
  endsequence
  sequence s_other_win;
    rd_req && win_hit && !table_busy && state_q == PSW_IDLE && !in_repeat && !is_move;
  endsequence

  a_move_one_extra: assert property (@(posedge sys_clk) disable iff (rst)
    s_move_win |-> ##2 rd_valid) else $error("move window read not answered after one extra cycle");
  a_other_two_extra: assert property (@(posedge sys_clk) disable iff (rst)
    s_other_win |-> !rd_valid ##2 !rd_valid ##1 rd_valid) else $error("other window read timing wrong");
  a_repeat_fast: assert property (@(posedge sys_clk) disable iff (rst)
    take_win && in_repeat && !rpt_edge |-> !rd_stall ##1 rd_valid) else $error("repeat iteration not single cycle");
  a_repeat_edge: assert property (@(posedge sys_clk) disable iff (rst)
    take_win && in_repeat && rpt_edge |-> ##3 rd_valid) else $error("repeat edge iteration timing wrong");
  a_table_hold: assert property (@(posedge sys_clk) disable iff (rst)
    table_busy && state_q == PSW_IDLE |-> !fif.start && !take_win) else $error("window used during table access");
  a_data_plain: assert property (@(posedge sys_clk) disable iff (rst)
    rd_req && !win_hit |-> !rd_stall ##1 rd_valid && rd_data == $past(dmem_rdata)) else $error("data read delayed");
  a_page_addr: assert property (@(posedge sys_clk) disable iff (rst)
    pmem_re |-> pmem_addr[PAGE_W+OFS_W-1:OFS_W] == window_page_register) else $error("page bits wrong");
  a_low_word: assert property (@(posedge sys_clk) disable iff (rst)
    state_q == PSW_FETCH && fif.last |=> rd_data == $past(pmem_rdata[`PSW_DATA_W-1:0])) else $error("bad low word");
  a_msb_gate: assert property (@(posedge sys_clk) disable iff (rst)
    take_win |-> data_effective_address[`PSW_WIN_MSB] && win_en) else $error("window without msb and enable");
  a_reset_off: assert property (@(posedge sys_clk)
    $fell(rst) |-> !win_en) else $error("enable set after reset");

  // Helper: length of an unbroken stall that no table access explains
  // Saturates so a hang shows as a stuck maximum, not a wrap to zero
  logic [2:0] stall_run_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stall_run_q <= '0;
    end else if (rd_stall && !table_busy) begin
      if (stall_run_q != `PSW_RUN_SAT) begin
        stall_run_q <= stall_run_q + 3'h1;
      end
    end else begin
      stall_run_q <= '0;
    end
  end

  // Steps of the longer window behaviours
  sequence s_edge_win;
    take_win && in_repeat && rpt_edge;
  endsequence
  sequence s_mid_win;
    take_win && in_repeat && !rpt_edge;
  endsequence
  sequence s_two_fetch;
    pmem_re ##1 pmem_re;
  endsequence
  sequence s_held_off;
    rd_req && win_hit && table_busy && state_q == PSW_IDLE;
  endsequence

  // Counted window reads: two fetches, stall while counting, clean return
  a_fetch_pair: assert property (@(posedge sys_clk) disable iff (rst)
    fif.start |-> s_two_fetch)
    else $error("window read without two fetches");

  a_fetch_stall: assert property (@(posedge sys_clk) disable iff (rst)
    state_q == PSW_FETCH |-> rd_stall && fif.busy)
    else $error("fetch state without stall");

  a_done_return: assert property (@(posedge sys_clk) disable iff (rst)
    state_q == PSW_DONE |=> state_q == PSW_IDLE)
    else $error("sequencer stuck after answer");

  a_fetch_answer: assert property (@(posedge sys_clk) disable iff (rst)
    state_q == PSW_FETCH && fif.last |=> rd_valid)
    else $error("last fetch cycle not answered");

  a_stall_bound: assert property (@(posedge sys_clk) disable iff (rst)
    stall_run_q <= `PSW_STALL_MAX)
    else $error("stall longer than the added cycles allow");

  // Stall lengths per instruction class, outside and inside repeat loops
  a_move_stall: assert property (@(posedge sys_clk) disable iff (rst)
    s_move_win |-> rd_stall ##1 rd_stall ##1 !fif.busy)
    else $error("move window stall length wrong");

  a_other_stall: assert property (@(posedge sys_clk) disable iff (rst)
    s_other_win |-> rd_stall [*3] ##1 !fif.busy)
    else $error("other window stall length wrong");

  a_edge_stall: assert property (@(posedge sys_clk) disable iff (rst)
    s_edge_win |-> rd_stall [*3] ##1 !fif.busy)
    else $error("repeat edge stall length wrong");

  a_mid_no_count: assert property (@(posedge sys_clk) disable iff (rst)
    s_mid_win |-> !fif.start ##1 !fif.busy)
    else $error("repeat middle iteration counted extra cycles");

  // Table accesses hold the window off entirely
  a_table_refuse: assert property (@(posedge sys_clk) disable iff (rst)
    s_held_off |-> rd_stall && !pmem_re)
    else $error("window fetched during table access");

  a_table_quiet: assert property (@(posedge sys_clk) disable iff (rst)
    s_held_off |=> !rd_valid)
    else $error("answer given during table access");

  // Routing between the two memories
  a_data_route: assert property (@(posedge sys_clk) disable iff (rst)
    rd_req && !win_hit && state_q == PSW_IDLE |-> dmem_re && !pmem_re && !fif.start)
    else $error("data read reached program memory");

  a_window_no_data: assert property (@(posedge sys_clk) disable iff (rst)
    win_hit |-> !dmem_re)
    else $error("window read reached data memory");

  a_data_addr: assert property (@(posedge sys_clk) disable iff (rst)
    dmem_re |-> dmem_addr == data_effective_address)
    else $error("data address altered");

  a_offset_map: assert property (@(posedge sys_clk) disable iff (rst)
    pmem_re |-> pmem_addr[OFS_W-1:0] == data_effective_address[OFS_W-1:0])
    else $error("offset bits not mapped straight");

  a_window_only: assert property (@(posedge sys_clk) disable iff (rst)
    pmem_re |-> data_effective_address[`PSW_WIN_MSB])
    else $error("program fetch below the window");

  a_valid_cause: assert property (@(posedge sys_clk) disable iff (rst)
    rd_valid |-> $past(rd_req))
    else $error("answer without a request");

  // Register behaviour
  a_page_hold: assert property (@(posedge sys_clk) disable iff (rst)
    !page_we |=> $stable(window_page_register))
    else $error("page changed without a write");

  a_page_load: assert property (@(posedge sys_clk) disable iff (rst)
    page_we |=> window_page_register == $past(page_wdata))
    else $error("page write lost");

  a_ctrl_load: assert property (@(posedge sys_clk) disable iff (rst)
    ctrl_we |=> core_control_register == $past(ctrl_wdata))
    else $error("control write lost");

  a_reset_page: assert property (@(posedge sys_clk)
    $fell(rst) |-> window_page_register == `PSW_PAGE_RST)
    else $error("page not cleared by reset");
endmodule // psw_window

// file: sim/psw_mem_model.sv
// Partner memories answering the window block's data and program reads
`timescale 1ns/1ps
module psw_mem_model (
  // Clock
  input  wire logic        sys_clk,
  // Data memory
  input  wire logic        dmem_re,
  input  wire logic [15:0] dmem_addr,
  output logic      [15:0] dmem_rdata,
  // Program memory
  input  wire logic        pmem_re,
  input  wire logic [22:0] pmem_addr,
  output logic      [23:0] pmem_rdata
);
  logic [15:0] junk_q = 16'hA5A5;
  // Unselected memories show a changing pattern, so a stale word never passes
  always @(posedge sys_clk) junk_q <= ~junk_q + 16'h0001;
  // Contents derived from the address, readable in the same cycle
  assign dmem_rdata = dmem_re ? (dmem_addr ^ 16'hC35A) : junk_q;
  assign pmem_rdata = pmem_re ? {pmem_addr[22:15] ^ 8'h99, pmem_addr[15:0] ^ 16'h1E2D} : {junk_q[7:0], junk_q};
endmodule // psw_mem_model

// file: sim/tb_psw_window.sv
// Self-checking bench for the program space data window
`timescale 1ns/1ps
module tb_psw_window;
  logic        sys_clk = 1'b0, rst = 1'b1, ctrl_we = 1'b0, page_we = 1'b0, rd_req = 1'b0, en = 1'b0;
  logic        is_move = 1'b0, in_repeat = 1'b0, rpt_edge = 1'b0, table_busy = 1'b0;
  logic [15:0] ctrl_wdata = 16'h0000, addr = 16'h0000, dmem_rdata, dmem_addr, ccr, rd_data;
  logic [7:0]  page_wdata = 8'h00, page, pg = 8'h00;
  logic [22:0] pmem_addr;
  logic [23:0] pmem_rdata;
  logic        rd_stall, rd_valid, dmem_re, pmem_re;
  int          err_count = 0, n_checks = 0, cyc = 0;

  psw_window u_psw_window (.sys_clk, .rst, .ctrl_we, .ctrl_wdata, .page_we, .page_wdata,
    .core_control_register(ccr), .window_page_register(page), .rd_req, .data_effective_address(addr),
    .is_move, .in_repeat, .rpt_edge, .table_busy, .rd_stall, .rd_valid, .rd_data, .dmem_re,
    .dmem_addr, .dmem_rdata, .pmem_re, .pmem_addr, .pmem_rdata);
  psw_mem_model u_psw_mem_model (.sys_clk, .dmem_re, .dmem_addr, .dmem_rdata, .pmem_re, .pmem_addr, .pmem_rdata);

  // 125 MHz clock
  always #4 sys_clk = ~sys_clk;
  // Hang guard, far beyond the fewer than a hundred cycles the tests need
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      finish_test();
    end
  end

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Register write; mirror kept for expectations
  task automatic wr(input logic [15:0] c, input logic [7:0] p);
    @(posedge sys_clk);
    ctrl_we <= 1'b1; ctrl_wdata <= c; page_we <= 1'b1; page_wdata <= p;
    @(posedge sys_clk);
    ctrl_we <= 1'b0; page_we <= 1'b0; en = c[2]; pg = p;
    @(negedge sys_clk);
    chk(ccr, c); chk(page, p);
  endtask

  // One read, optionally refused by a table access for tbl cycles first
  task automatic rd(input logic [15:0] a, input logic mv, rpt, edg, input int tbl, lat);
    logic win;
    logic [22:0] pa;
    int n;
    win = a[15] & en;
    pa = {pg, a[14:0]};
    @(posedge sys_clk);
    rd_req <= 1'b1; addr <= a; is_move <= mv; in_repeat <= rpt; rpt_edge <= edg; table_busy <= (tbl > 0);
    repeat (tbl) begin
      @(negedge sys_clk);
      chk(rd_stall, 1'b1); chk(pmem_re, 1'b0);
    end
    if (tbl > 0) begin
      @(posedge sys_clk);
      table_busy <= 1'b0;
    end
    // Request dropped once the block stops stalling, so no second read is taken
    for (n = 0; n < 8; n++) begin
      @(negedge sys_clk);
      if (n == 0) chk(win ? pmem_re : dmem_re, 1'b1);
      if (n == 0 && win) chk(pmem_addr, pa);
      if (rd_valid === 1'b1) break;
      if (rd_stall === 1'b0) begin
        @(posedge sys_clk);
        rd_req <= 1'b0;
      end
    end
    chk(n, lat);
    chk(rd_data, win ? pa[15:0] ^ 16'h1E2D : a ^ 16'hC35A);
    if (rd_req) begin
      @(posedge sys_clk);
      rd_req <= 1'b0;
    end
  endtask

  task automatic t_reset;
    @(negedge sys_clk);
    chk(ccr, 16'h0000); chk(page, 8'h00);
    rd(16'h8004, 1'b0, 1'b0, 1'b0, 0, 1);
    $display("reset test done");
  endtask

  task automatic t_enable;
    wr(16'hFFFB, 8'h5A);
    rd(16'hC000, 1'b0, 1'b0, 1'b0, 0, 1);
    wr(16'h0004, 8'h5A);
    rd(16'h1234, 1'b0, 1'b0, 1'b0, 0, 1);
    rd(16'h7FFE, 1'b1, 1'b0, 1'b0, 0, 1);
    $display("enable test done");
  endtask

  task automatic t_window;
    rd(16'hFFFE, 1'b1, 1'b0, 1'b0, 0, 2);
    rd(16'h8000, 1'b0, 1'b0, 1'b0, 0, 3);
    wr(16'h0004, 8'hFF);
    rd(16'hAAAA, 1'b1, 1'b0, 1'b0, 0, 2);
    $display("window test done");
  endtask

  task automatic t_repeat;
    rd(16'h9000, 1'b0, 1'b1, 1'b0, 0, 1);
    rd(16'h9002, 1'b0, 1'b1, 1'b1, 0, 3);
    rd(16'h9004, 1'b1, 1'b1, 1'b1, 0, 3);
    rd(16'h9006, 1'b1, 1'b1, 1'b0, 0, 1);
    $display("repeat test done");
  endtask

  task automatic t_table;
    rd(16'hA000, 1'b0, 1'b0, 1'b0, 4, 3);
    @(posedge sys_clk);
    rst <= 1'b1;
    @(posedge sys_clk);
    rst <= 1'b0; en = 1'b0; pg = 8'h00;
    @(negedge sys_clk);
    chk(ccr, 16'h0000);
    rd(16'hA000, 1'b0, 1'b0, 1'b0, 0, 1);
    $display("table and reset test done");
  endtask

  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_enable();
    t_window();
    t_repeat();
    t_table();
    finish_test();
  end
endmodule // tb_psw_window
